/* File: pkg/i2c_host_map.vh */
/*
  Constants for the I2C host receive, acknowledge and stop sequencer.
  Assumes inclusion by bare name from the design files.
*/
`ifndef I2C_HOST_MAP_VH
`define I2C_HOST_MAP_VH
`define RELOAD_WIDTH 8
`define RELOAD_RESET 8'h13
`define BITS_PER_BYTE 4'h8
`define BYTE_RESET 8'h00
`endif

/* File: logic/pin_sync.v */
/*
  Two-flip-flop synchroniser for one asynchronous pin input.
  Assumes sys_clk is the only clock; reset is synchronous, active low.
*/
`timescale 1ns/1ps
module pin_sync (
  input wire sys_clk,
  input wire reset_n,
  input wire pinIn,
  output reg pinSync
);
  reg firstStage;
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      firstStage <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      firstStage <= pinIn;
      pinSync <= firstStage;
    end
  end
endmodule

/* File: logic/baud_gen.v */
/*
  Reloadable down-counting baud generator giving a one-cycle rollover pulse.
  Assumes reload values of three or more; load restarts the count.
*/
`timescale 1ns/1ps
`include "i2c_host_map.vh"
module baud_gen (
  input wire sys_clk,
  input wire reset_n,
  input wire run,
  input wire load,
  input wire [7:0] reloadValue,
  output wire rollover
);
  reg [7:0] count;
  assign rollover = run && !load && (count == 8'h00);
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      count <= 8'h00;
    end else if (load || !run || count == 8'h00) begin
      count <= reloadValue;
    end else begin
      count <= count - 8'h01;
    end
  end
endmodule

/* File: logic/i2c_host_seq.v */
/*
  I2C host sequencer: byte reception, acknowledge, stop, flags, bus monitor.
  Assumes SDA and SCL are open-drain wires with pull-ups outside; control
  bits arrive as one-cycle set pulses from software logic on sys_clk.
*/
// How it works
// RULE1 - Receive enable ignored unless port idle
// RULE2 - Each rollover toggles SCL, shifts in SDA (code shifts SDA in only at rollovers that release SCL)
// RULE3 - Eighth fall: load buffer, flags, hold SCL
// RULE4 - Buffer read clears buffer full
// RULE5 - New byte while full sets overflow
// RULE6 - Buffer write while receiving sets collision
// RULE7 - Software starts, addresses, then enables receive
// RULE8 - Ack enable: SCL low, ack bit on SDA
// RULE9 - Software chooses ack bit before sequence
// RULE10 - Release SCL, wait high, count again
// RULE11 - Then SCL low, clear enable, idle
// RULE12 - Buffer write during ack sets collision
// RULE13 - Stop: SDA low, then reload and count
// RULE14 - Timeout releases SCL, SDA one period later
// RULE15 - SDA high with SCL high sets stop-seen
// RULE16 - Period after stop-seen: clear enable, interrupt
// RULE17 - Buffer write during stop sets collision
// RULE18 - Reset disables port, aborts transfer
// RULE19 - Start/stop seen cleared on reset, disable
// RULE20 - Software takes bus only when free
// RULE21 - Busy bus stop raises enabled interrupt
// RULE22 - SDA compared with intended output level
// RULE23 - Collision sets flag, returns to idle
// RULE24 - Software avoids reload values zero to two
// RULE25 - Open-drain pins, inputs synchronised first
`timescale 1ns/1ps
`include "i2c_host_map.vh"
module i2c_host_seq (
  input wire sys_clk,
  input wire reset_n,
  input wire portEnable,
  input wire [7:0] baudReload,
  input wire setReceiveEnable,
  input wire setAckEnable,
  input wire setStopEnable,
  input wire ackDataValue,
  input wire bufferRead,
  input wire bufferWrite,
  input wire [7:0] bufferWriteData,
  input wire clearInterrupt,
  input wire clearOverflow,
  input wire clearWriteCollision,
  input wire clearBusCollision,
  input wire interruptEnable,
  input wire sdaIn,
  input wire sclIn,
  output reg sdaOut,
  output reg sdaOe,
  output reg sclOut,
  output reg sclOe,
  output reg [7:0] bufferData,
  output reg receiveEnable,
  output reg ackSequenceEnable,
  output reg stopSequenceEnable,
  output reg bufferFull,
  output reg receiveOverflow,
  output reg writeCollision,
  output reg busCollision,
  output reg portInterrupt,
  output reg startSeen,
  output reg stopSeen,
  output wire interruptOut
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_ACK_LOW = 3'd2;
  localparam ST_ACK_WAIT = 3'd3;
  localparam ST_ACK_HIGH = 3'd4;
  localparam ST_STOP_SDA = 3'd5;
  localparam ST_STOP_SCL = 3'd6;
  localparam ST_STOP_END = 3'd7;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus monitor
  wire sdaSync;
  wire sclSync;
  reg sdaPrev;
  reg sclPrev;
  pin_sync sdaSyncInst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(sdaIn),
    .pinSync(sdaSync)
  ); // [RULE25]
  pin_sync sclSyncInst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(sclIn),
    .pinSync(sclSync)
  ); // [RULE25]
  wire startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
  wire stopCond = sclSync && sclPrev && !sdaPrev && sdaSync;

  //////////////////////////////////////////////////////////////////////////////
  // Baud generator
  reg [2:0] state;
  reg [2:0] next_state;
  reg baudRun;
  reg baudLoad;
  wire rollover;
  baud_gen baudInst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(baudRun),
    .load(baudLoad),
    .reloadValue(baudReload),
    .rollover(rollover)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg [7:0] shiftReg;
  reg [3:0] fallCount;
  reg sclDrive;
  reg sdaDrive;
  reg stopLatched;
  wire idle = (state == ST_IDLE);
  // Collision: released SDA read low while SCL high in ST_ACK_WAIT or ST_ACK_HIGH, or at a rollover in ST_STOP_END
  wire arbLost = sclSync && !sdaDrive && !sdaSync &&
    (state == ST_ACK_WAIT || state == ST_ACK_HIGH); // [RULE22]
  wire stopCollision = (state == ST_STOP_END) && rollover && !sdaDrive && !sdaSync;

  always @* begin
    baudRun = 1'b0;
    baudLoad = 1'b0;
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (setReceiveEnable) begin
          next_state = ST_RX; // [RULE1]
          baudLoad = 1'b1;
        end else if (setAckEnable) begin
          next_state = ST_ACK_LOW;
          baudLoad = 1'b1;
        end else if (setStopEnable) begin
          next_state = ST_STOP_SDA;
          baudLoad = 1'b1;
        end
      end
      ST_RX: begin
        baudRun = 1'b1;
      end
      ST_ACK_LOW: begin
        baudRun = 1'b1;
      end
      ST_ACK_WAIT: begin
        baudLoad = 1'b1; // [RULE10]
      end
      ST_ACK_HIGH: begin
        baudRun = 1'b1;
      end
      ST_STOP_SDA: begin
        baudLoad = 1'b1;
      end
      default: begin
        baudRun = 1'b1;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!reset_n || !portEnable) begin
      state <= ST_IDLE; // [RULE18]
      sclDrive <= 1'b0;
      sdaDrive <= 1'b0;
      shiftReg <= `BYTE_RESET;
      fallCount <= 4'h0;
      bufferData <= `BYTE_RESET;
      receiveEnable <= 1'b0;
      ackSequenceEnable <= 1'b0;
      stopSequenceEnable <= 1'b0;
      bufferFull <= 1'b0;
      receiveOverflow <= 1'b0;
      writeCollision <= 1'b0;
      busCollision <= 1'b0;
      portInterrupt <= 1'b0;
      startSeen <= 1'b0; // [RULE19]
      stopSeen <= 1'b0; // [RULE19]
      stopLatched <= 1'b0;
      sdaPrev <= 1'b1;
      sclPrev <= 1'b1;
    end else begin
      sdaPrev <= sdaSync;
      sclPrev <= sclSync;
      if (startCond) begin
        startSeen <= 1'b1;
        stopSeen <= 1'b0;
      end else if (stopCond) begin
        stopSeen <= 1'b1; // [RULE15]
        startSeen <= 1'b0;
      end
      // Flags: set wins over clear
      if (clearInterrupt) portInterrupt <= 1'b0;
      if (clearOverflow) receiveOverflow <= 1'b0;
      if (clearWriteCollision) writeCollision <= 1'b0;
      if (clearBusCollision) busCollision <= 1'b0;
      if (bufferRead) bufferFull <= 1'b0; // [RULE4]
      if (bufferWrite) begin
        if (!idle) begin
          writeCollision <= 1'b1; // [RULE6] [RULE12] [RULE17]
        end else begin
          bufferData <= bufferWriteData;
        end
      end
      if (stopCond && state != ST_STOP_END && state != ST_STOP_SCL) begin
        portInterrupt <= 1'b1; // [RULE21]
      end
      state <= next_state;
      case (state)
        ST_IDLE: begin
          if (setReceiveEnable) begin
            receiveEnable <= 1'b1;
            fallCount <= 4'h0;
            sclDrive <= 1'b1;
            sdaDrive <= 1'b0;
          end else if (setAckEnable) begin
            ackSequenceEnable <= 1'b1;
            sclDrive <= 1'b1; // [RULE8]
            sdaDrive <= !ackDataValue; // [RULE8]
          end else if (setStopEnable) begin
            stopSequenceEnable <= 1'b1;
            sdaDrive <= 1'b1; // [RULE13]
          end
        end
        ST_RX: begin
          if (rollover) begin
            sclDrive <= !sclDrive; // [RULE2]
            if (sclDrive) begin
              shiftReg <= {shiftReg[6:0], sdaSync}; // [RULE2]
            end else begin
              fallCount <= fallCount + 4'h1;
              if (fallCount + 4'h1 == `BITS_PER_BYTE) begin
                receiveEnable <= 1'b0; // [RULE3]
                bufferData <= shiftReg;
                bufferFull <= 1'b1;
                portInterrupt <= 1'b1;
                if (bufferFull && !bufferRead) receiveOverflow <= 1'b1; // [RULE5]
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_ACK_LOW: begin
          if (rollover) begin
            sclDrive <= 1'b0; // [RULE10]
            state <= ST_ACK_WAIT;
          end
        end
        ST_ACK_WAIT: begin
          if (sclSync) state <= ST_ACK_HIGH; // [RULE10]
        end
        ST_ACK_HIGH: begin
          if (rollover) begin
            sclDrive <= 1'b1; // [RULE11]
            sdaDrive <= 1'b0;
            ackSequenceEnable <= 1'b0; // [RULE11]
            portInterrupt <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_STOP_SDA: begin
          if (!sdaSync) state <= ST_STOP_SCL; // [RULE13]
        end
        ST_STOP_SCL: begin
          if (rollover) begin
            sclDrive <= 1'b0; // [RULE14]
            state <= ST_STOP_END;
            stopLatched <= 1'b0;
          end
        end
        default: begin
          if (rollover) begin
            if (sdaDrive) begin
              sdaDrive <= 1'b0; // [RULE14]
            end else if (stopLatched) begin
              stopSequenceEnable <= 1'b0; // [RULE16]
              portInterrupt <= 1'b1; // [RULE16]
              state <= ST_IDLE;
            end
          end
          if (stopCond) stopLatched <= 1'b1;
        end
      endcase
      if (arbLost || stopCollision) begin
        busCollision <= 1'b1; // [RULE23]
        state <= ST_IDLE; // [RULE23]
        sclDrive <= 1'b0;
        sdaDrive <= 1'b0;
        receiveEnable <= 1'b0;
        ackSequenceEnable <= 1'b0;
        stopSequenceEnable <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Open-drain pin drive
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end else begin
      sdaOut <= 1'b0; // [RULE25]
      sclOut <= 1'b0; // [RULE25]
      sdaOe <= sdaDrive;
      sclOe <= sclDrive;
    end
  end

  assign interruptOut = portInterrupt && interruptEnable;
endmodule

/* File: bench/i2c_host_seq_assertions.sv */
/* Port checker for the I2C host sequencer.
   Assumes one sys_clk domain; bound to every sequencer instance. */
`timescale 1ns/1ps
module i2c_host_seq_assertions (
  input wire sys_clk,
  input wire reset_n,
  input wire portEnable,
  input wire setAckEnable,
  input wire ackDataValue,
  input wire bufferWrite,
  input wire bufferRead,
  input wire sclIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire sclOut,
  input wire sclOe,
  input wire receiveEnable,
  input wire ackSequenceEnable,
  input wire stopSequenceEnable,
  input wire bufferFull,
  input wire receiveOverflow,
  input wire writeCollision,
  input wire busCollision,
  input wire portInterrupt,
  input wire startSeen,
  input wire stopSeen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n || !portEnable);
  ////////////////////////////////////////////////////////////////////////////
  property p_pins; !sdaOut && !sclOut; endproperty
  a_pins: assert property (p_pins) else $error("pin driven high");
  property p_rxBusy; receiveEnable && setAckEnable |=> !ackSequenceEnable; endproperty
  a_rxBusy: assert property (p_rxBusy) else $error("ack taken while busy");
  property p_rxDone;
    $fell(receiveEnable) |-> bufferFull && portInterrupt ##1 sclOe;
  endproperty
  a_rxDone: assert property (p_rxDone) else $error("byte end flags");
  property p_ovf;
    $fell(receiveEnable) && $past(bufferFull) && !$past(bufferRead) |-> receiveOverflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missing");
  property p_write_collision_flag;
    bufferWrite && (receiveEnable || ackSequenceEnable || stopSequenceEnable) |=> writeCollision;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missing");
  property p_ackStart; $rose(ackSequenceEnable) |=> sclOe && (sdaOe == !ackDataValue); endproperty
  a_ackStart: assert property (p_ackStart) else $error("ack drive");
  property p_ackWait; ackSequenceEnable && !sclOe && !sclIn |=> ackSequenceEnable; endproperty
  a_ackWait: assert property (p_ackWait) else $error("ack ended while stretched");
  property p_ackEnd; $fell(ackSequenceEnable) && !busCollision |=> sclOe && !sdaOe; endproperty
  a_ackEnd: assert property (p_ackEnd) else $error("ack end lines");
  property p_stopEnd;
    $fell(stopSequenceEnable) && !busCollision |-> stopSeen && portInterrupt && !sdaOe && !sclOe;
  endproperty
  a_stopEnd: assert property (p_stopEnd) else $error("stop end");
  property p_off;
    disable iff (!reset_n)
    !portEnable |=> !receiveEnable && !ackSequenceEnable && !startSeen && !stopSeen;
  endproperty
  a_off: assert property (p_off) else $error("disable leaves state");
endmodule
bind i2c_host_seq i2c_host_seq_assertions chk (.*);

/* File: bench/i2c_client_model.sv */
/* Client device: returns one byte MSB first on SDA and can stretch SCL.
   Assumes open-drain lines with pull-ups resolved in the bench. */
`timescale 1ns/1ps
module i2c_client_model (
  input wire sclLine,
  input wire start,
  input wire stretch,
  input wire [7:0] txByte,
  output wire sdaPull,
  output wire sclPull
);
  integer falls = 9;
  ////////////////////////////////////////////////////////////////////////////
  // Data changes only while SCL is low
  always @(posedge start) falls = sclLine ? 0 : 1;
  always @(negedge sclLine) if (falls < 9) falls = falls + 1;
  // Released after the byte, so the pull-up gives high
  assign sdaPull = (falls >= 1 && falls <= 8) ? !txByte[8 - falls] : 1'b0;
  assign sclPull = stretch;
endmodule

/* File: bench/i2c_host_seq_tb.sv */
/* Testbench for the I2C host sequencer with a client model and a second host.
   Assumes 40 MHz sys_clk and pull-ups on both lines. */
`timescale 1ns/1ps
module i2c_host_seq_tb;
  reg sys_clk = 0, reset_n = 0, portEnable = 0, ackDataValue = 0, interruptEnable = 0;
  reg setReceiveEnable = 0, setAckEnable = 0, setStopEnable = 0, bufferWrite = 0;
  reg bufferRead = 0, clearInterrupt = 0, clearWriteCollision = 0;
  reg clearOverflow = 0, clearBusCollision = 0, start = 0, stretch = 0, otherSda = 0, seenOe;
  reg [7:0] baudReload = 8'h03, bufferWriteData = 8'hee, txByte = 8'h00;
  wire sdaOut, sdaOe, sclOut, sclOe, receiveEnable, ackSequenceEnable, stopSequenceEnable;
  wire bufferFull, receiveOverflow, writeCollision, busCollision, portInterrupt;
  wire startSeen, stopSeen, interruptOut, sdaPull, sclPull;
  wire [7:0] bufferData;
  wire sdaIn = !(sdaOe || sdaPull || otherSda);
  wire sclIn = !(sclOe || sclPull);
  integer fail_count = 0, check_count = 0, a, i;
  i2c_host_seq DUT (.*);
  i2c_client_model client (.sclLine(sclIn), .start(start), .stretch(stretch),
    .txByte(txByte), .sdaPull(sdaPull), .sclPull(sclPull));
  initial forever #12.5 sys_clk = !sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [7:0] exp, input [7:0] got, input string nm);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle control pulses
  task pulse(input [6:0] k);
    @(negedge sys_clk);
    {setReceiveEnable, setAckEnable, bufferWrite, bufferRead, setStopEnable,
      clearInterrupt, clearWriteCollision} = k;
    @(negedge sys_clk);
    {setReceiveEnable, setAckEnable, bufferWrite, bufferRead, setStopEnable,
      clearInterrupt, clearWriteCollision} = 7'h00;
  endtask
  task settle;
    for (i = 0; i < 400 && (receiveEnable || ackSequenceEnable || stopSequenceEnable); i++)
      @(negedge sys_clk);
    chk(0, i == 400, "settleLimit");
    // Pin enables follow the sequence bits one cycle later
    @(negedge sys_clk);
  endtask
  task give_verdict;
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1;
    portEnable = 1;
    repeat (3) @(negedge sys_clk);
    // Two bytes, second one with the first unread
    for (a = 0; a < 2; a = a + 1) begin
      txByte = a ? 8'h3c : 8'ha5;
      start = 1;
      pulse(7'h43);
      start = 0;
      pulse(7'h20);
      chk(0, ackSequenceEnable, "ackIgnored");
      pulse(7'h10);
      settle;
      chk(txByte, bufferData, "rxByte");
      chk(1, bufferFull & portInterrupt & sclOe, "rxEnd");
      chk(1, writeCollision, "rxWcol");
      chk(a, receiveOverflow, "overflow");
    end
    pulse(7'h08);
    chk(0, bufferFull, "fullAfterRead");
    // Ack then nack, client stretching SCL
    for (a = 0; a < 2; a = a + 1) begin
      ackDataValue = a;
      stretch = 1;
      pulse(7'h03);
      pulse(7'h20);
      pulse(7'h10);
      @(negedge sys_clk);
      seenOe = sdaOe;
      repeat (12) @(negedge sys_clk);
      chk(1, ackSequenceEnable, "ackStretched");
      stretch = 0;
      settle;
      chk(!a, seenOe, "ackBit");
      chk(1, sclOe & !sdaOe, "ackEnd");
      chk(8'h3c, bufferData, "ackBuffer");
      chk(1, writeCollision, "ackWcol");
    end
    // Stop
    pulse(7'h03);
    pulse(7'h04);
    pulse(7'h10);
    settle;
    chk(1, stopSeen & portInterrupt, "stopEnd");
    chk(0, sdaOe | sclOe, "stopRelease");
    chk(8'h3c, bufferData, "stopBuffer");
    chk(1, writeCollision, "stopWcol");
    // Start and stop by another host
    pulse(7'h02);
    interruptEnable = 1;
    otherSda = 1;
    repeat (6) @(negedge sys_clk);
    chk(1, startSeen & !stopSeen, "startSeen");
    otherSda = 0;
    repeat (6) @(negedge sys_clk);
    chk(1, stopSeen & interruptOut, "busyStop");
    // Other host holds SDA low through our stop
    otherSda = 1;
    pulse(7'h04);
    settle;
    chk(1, busCollision, "stopCollision");
    otherSda = 0;
    // Other host pulls SDA low under our released nack bit
    clearBusCollision = 1;
    pulse(7'h20);
    clearBusCollision = 0;
    otherSda = 1;
    settle;
    chk(1, busCollision & !ackSequenceEnable, "ackCollision");
    otherSda = 0;
    // Disable one cycle after a byte receive starts
    start = 1;
    pulse(7'h40);
    portEnable = 0;
    repeat (3) @(negedge sys_clk);
    chk(0, {receiveEnable, sclOe, startSeen, stopSeen, busCollision}, "disabled");
    give_verdict;
  end
endmodule
